// File: design/fcp_pkg.sv
package fcp_pkg;
	localparam int CMD_BYTES = 32;
	localparam int XRDY_BYTES = 12;
	localparam int LUN_LO = 0;
	localparam int CNTL_LO = 8;
	localparam int CDB_LO = 12;
	localparam int DL_LO = 28;
	localparam int RO_LO = 0;
	localparam int BL_LO = 4;
	localparam int ATTR_BYTE = 1;
	localparam int TMF_BYTE = 2;
	localparam int DIR_BYTE = 3;
	localparam logic [3:0] CAT_DATA = 4'h1;
	localparam logic [3:0] CAT_XRDY = 4'h5;
	localparam logic [3:0] CAT_CMD = 4'h6;
	localparam logic [3:0] CAT_RSP = 4'h7;
	localparam logic [63:0] LUN_ZERO = 64'h0000000000000000;
	localparam logic [2:0] ATTR_SIMPLE = 3'h0;
	localparam logic [2:0] ATTR_HEAD = 3'h1;
	localparam logic [2:0] ATTR_ORDERED = 3'h2;
	localparam logic [2:0] ATTR_ACA = 3'h4;
	localparam logic [2:0] ATTR_UNTAGGED = 3'h5;
	localparam logic [7:0] TMF_TERM = 8'h80;
	localparam logic [7:0] TMF_CLRACA = 8'h40;
	localparam logic [7:0] TMF_TRESET = 8'h20;
	localparam logic [7:0] TMF_CLRSET = 8'h04;
	localparam logic [7:0] TMF_ABTSET = 8'h02;
	localparam int DIR_RD_BIT = 1;
	localparam int DIR_WR_BIT = 0;
	localparam logic [7:0] RC_OK = 8'h00;
	localparam logic [7:0] RC_BURST = 8'h01;
	localparam logic [7:0] RC_INVALID = 8'h02;
	localparam logic [7:0] RC_REJECT = 8'h04;
	typedef enum logic [1:0] {
		FCP_Q_SIMPLE = 2'b00,
		FCP_Q_HEAD = 2'b01,
		FCP_Q_ORDERED = 2'b10
	} fcp_queue_t;
endpackage

// File: design/fcp_link_if.sv
`timescale 1ns/1ns
// One byte per cycle, both directions; sof/eof frame each unit
interface fcp_link_if;
	logic		i2t_valid;
	logic [7:0]	i2t_data;
	logic [3:0]	i2t_cat;
	logic		i2t_sof;
	logic		i2t_eof;
	logic [15:0]	i2t_xid;
	logic		t2i_valid;
	logic [7:0]	t2i_data;
	logic [3:0]	t2i_cat;
	logic		t2i_sof;
	logic		t2i_eof;
	logic [15:0]	t2i_xid;
	modport target (
		input	i2t_valid, i2t_data, i2t_cat, i2t_sof, i2t_eof,
			i2t_xid,
		output	t2i_valid, t2i_data, t2i_cat, t2i_sof, t2i_eof,
			t2i_xid
	);
	modport initiator (
		output	i2t_valid, i2t_data, i2t_cat, i2t_sof, i2t_eof,
			i2t_xid,
		input	t2i_valid, t2i_data, t2i_cat, t2i_sof, t2i_eof,
			t2i_xid
	);
endinterface

// File: design/fcp_target.sv
`timescale 1ns/1ns
// Function
// RQ1 - Fixed unit set with categories 6,5,1,7; no category 7 unit is sent, response code only on O_RSP_CODE
// RQ2 - One exchange per task, exchange ID tag
// RQ3 - Command payload 32 bytes, fixed layout
// RQ4 - Single logical unit, number all zeros
// RQ5 - Control field: reserved, attribute, flags, direction
// RQ6 - Attribute low three bits; ACA unsupported
// RQ7 - Management flag byte decoded one-hot
// RQ8 - Direction bit 1 read, bit 0 write
// RQ9 - Management flag set: descriptor ignored
// RQ10 - Descriptor always 16 bytes, tail ignored
// RQ11 - Data length bounds the transfer
// RQ12 - Zero length: no ready, no data
// RQ13 - Ready only when prepared for data
// RQ14 - Initiator sends exactly requested bytes
// RQ15 - Ready payload: offset, burst, reserved
// RQ16 - Burst equals space set aside
// RQ17 - Burst not above configured maximum
// RQ18 - Wrong data length gives code 01h
// RQ19 - Untagged handled as ordered
// RQ20 - Multi-byte fields most significant first
// RQ21 - Reject unsupported attribute or clear ACA
module fcp_target (
	input	wire logic			I_CLK,
	input	wire logic			I_RST,
	fcp_link_if.target			LINK,
	input	wire logic [31:0]		I_MAX_BURST,
	input	wire logic			I_BUF_READY,
	output	logic				O_CMD_VALID,
	output	logic [15:0]			O_CMD_TAG,
	output	logic [127:0]			O_CMD_CDB,
	output	logic [31:0]			O_CMD_DL,
	output	logic				O_CMD_READ,
	output	logic				O_CMD_WRITE,
	output	logic [1:0]			O_CMD_QUEUE,
	output	logic				O_TMF_VALID,
	output	logic [7:0]			O_TMF_FLAGS,
	output	logic				O_REJECT,
	output	logic				O_WDATA_VALID,
	output	logic [7:0]			O_WDATA,
	output	logic				O_DONE,
	output	logic [7:0]			O_RSP_CODE
);
	typedef enum logic [2:0] {
		FCP_T_IDLE = 3'b000,
		FCP_T_CMD = 3'b001,
		FCP_T_DEC = 3'b010,
		FCP_T_WAIT = 3'b011,
		FCP_T_XRDY = 3'b100,
		FCP_T_DATA = 3'b101
	} fcp_tstate_t;
	typedef struct packed {
		fcp_tstate_t	st;
		logic [255:0]	cmd;
		logic [5:0]	cnt;
		logic [15:0]	xid;
		logic [31:0]	offset;
		logic [31:0]	burst;
		logic [31:0]	got;
		logic		cv;
		logic		tv;
		logic		rej;
		logic		dv;
		logic [7:0]	dat;
		logic		done;
		logic [7:0]	rc;
		logic [95:0]	xr;
	} fcp_tgt_t;
	fcp_tgt_t r;
	fcp_tgt_t next_r;
	logic [63:0] lun;
	logic [7:0] attr;
	logic [7:0] tmf;
	logic [7:0] dir;
	logic [31:0] dl;
	logic [31:0] left;
	logic [31:0] bl;
	logic bad;
	// RQ3 payload slices
	// RQ20 first byte lands in the top bits
	assign lun = r.cmd[255-fcp_pkg::LUN_LO*8 -: 64];
	// RQ5 attribute, flags, direction
	assign attr = r.cmd[255-(fcp_pkg::CNTL_LO+fcp_pkg::ATTR_BYTE)*8 -: 8];
	assign tmf = r.cmd[255-(fcp_pkg::CNTL_LO+fcp_pkg::TMF_BYTE)*8 -: 8];
	assign dir = r.cmd[255-(fcp_pkg::CNTL_LO+fcp_pkg::DIR_BYTE)*8 -: 8];
	assign dl = r.cmd[255-fcp_pkg::DL_LO*8 -: 32];
	// RQ11 remaining bound
	assign left = dl - r.offset;
	// RQ17 clamp to configured maximum
	assign bl = (left > I_MAX_BURST) ? I_MAX_BURST : left;
	// RQ7 one-hot: more than one flag is invalid
	assign bad = (tmf & (tmf - 8'h01)) != 8'h00;
	always_comb begin
		next_r = r;
		next_r.cv = 1'b0;
		next_r.tv = 1'b0;
		next_r.rej = 1'b0;
		next_r.dv = 1'b0;
		next_r.done = 1'b0;
		case (r.st)
			FCP_T_IDLE: begin
				// RQ1 command unit opens the exchange
				if (LINK.i2t_valid && LINK.i2t_sof &&
				    LINK.i2t_cat == fcp_pkg::CAT_CMD) begin
					next_r.cmd = {r.cmd[247:0], LINK.i2t_data};
					next_r.cnt = 6'd1;
					// RQ2 exchange ID becomes the tag
					next_r.xid = LINK.i2t_xid;
					next_r.offset = 32'h0;
					next_r.st = FCP_T_CMD;
				end
			end
			FCP_T_CMD: begin
				if (LINK.i2t_valid) begin
					next_r.cmd = {r.cmd[247:0], LINK.i2t_data};
					next_r.cnt = r.cnt + 6'd1;
					if (LINK.i2t_eof) begin
						next_r.st = FCP_T_DEC;
					end
				end
			end
			FCP_T_DEC: begin
				next_r.st = FCP_T_IDLE;
				next_r.rc = fcp_pkg::RC_OK;
				// RQ4 only the zero unit answers
				if (r.cnt != 6'(fcp_pkg::CMD_BYTES) ||
				    lun != fcp_pkg::LUN_ZERO || bad) begin
					next_r.rej = 1'b1;
					next_r.done = 1'b1;
					next_r.rc = fcp_pkg::RC_INVALID;
				// RQ21 clear ACA rejected
				end else if (tmf == fcp_pkg::TMF_CLRACA) begin
					next_r.rej = 1'b1;
					next_r.done = 1'b1;
					next_r.rc = fcp_pkg::RC_REJECT;
				// RQ9 management skips the descriptor
				end else if (tmf != 8'h00) begin
					next_r.tv = 1'b1;
					next_r.done = 1'b1;
				// RQ6 ACA queueing unsupported
				end else if (attr[2:0] != fcp_pkg::ATTR_SIMPLE &&
				    attr[2:0] != fcp_pkg::ATTR_HEAD &&
				    attr[2:0] != fcp_pkg::ATTR_ORDERED &&
				    attr[2:0] != fcp_pkg::ATTR_UNTAGGED) begin
					next_r.rej = 1'b1;
					next_r.done = 1'b1;
					next_r.rc = fcp_pkg::RC_REJECT;
				end else begin
					next_r.cv = 1'b1;
					// RQ8 write moves data toward target
					// RQ12 zero length: no data phase
					if (dir[fcp_pkg::DIR_WR_BIT] && dl != 32'h0) begin
						next_r.st = FCP_T_WAIT;
					end else begin
						next_r.done = 1'b1;
					end
				end
			end
			FCP_T_WAIT: begin
				// RQ13 ready only once buffer is reserved
				if (I_BUF_READY) begin
					// RQ16 burst is the space set aside
					next_r.burst = bl;
					// RQ15 offset, burst, reserved
					next_r.xr = {r.offset, bl, 32'h0};
					next_r.cnt = 6'd0;
					next_r.st = FCP_T_XRDY;
				end
			end
			FCP_T_XRDY: begin
				next_r.xr = {r.xr[87:0], 8'h00};
				next_r.cnt = r.cnt + 6'd1;
				if (r.cnt == 6'(fcp_pkg::XRDY_BYTES - 1)) begin
					next_r.got = 32'h0;
					next_r.st = FCP_T_DATA;
				end
			end
			FCP_T_DATA: begin
				if (LINK.i2t_valid &&
				    LINK.i2t_cat == fcp_pkg::CAT_DATA &&
				    LINK.i2t_xid == r.xid) begin
					next_r.got = r.got + 32'h1;
					next_r.dv = 1'b1;
					next_r.dat = LINK.i2t_data;
					if (LINK.i2t_eof) begin
						// RQ14 initiator owes the exact count
						// RQ18 mismatch reports code 01h
						if (r.got + 32'h1 != r.burst) begin
							next_r.rc = fcp_pkg::RC_BURST;
							next_r.done = 1'b1;
							next_r.st = FCP_T_IDLE;
						end else if (r.offset + r.burst >= dl) begin
							next_r.done = 1'b1;
							next_r.st = FCP_T_IDLE;
						end else begin
							next_r.offset = r.offset + r.burst;
							next_r.st = FCP_T_WAIT;
						end
					end
				end
			end
			default: begin
				next_r.st = FCP_T_IDLE;
			end
		endcase
	end
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	assign LINK.t2i_valid = (r.st == FCP_T_XRDY);
	assign LINK.t2i_data = r.xr[95:88];
	assign LINK.t2i_cat = fcp_pkg::CAT_XRDY;
	assign LINK.t2i_sof = (r.st == FCP_T_XRDY) && r.cnt == 6'd0;
	assign LINK.t2i_eof = (r.st == FCP_T_XRDY) &&
	    r.cnt == 6'(fcp_pkg::XRDY_BYTES - 1);
	assign LINK.t2i_xid = r.xid;
	assign O_CMD_VALID = r.cv;
	assign O_CMD_TAG = r.xid;
	// RQ10 all 16 bytes passed; caller uses its length
	assign O_CMD_CDB = r.cmd[255-fcp_pkg::CDB_LO*8 -: 128];
	assign O_CMD_DL = dl;
	assign O_CMD_READ = dir[fcp_pkg::DIR_RD_BIT];
	assign O_CMD_WRITE = dir[fcp_pkg::DIR_WR_BIT];
	// RQ19 untagged queued as ordered
	assign O_CMD_QUEUE = (attr[2:0] == fcp_pkg::ATTR_HEAD) ?
	    2'(fcp_pkg::FCP_Q_HEAD) : (attr[2:0] == fcp_pkg::ATTR_SIMPLE) ?
	    2'(fcp_pkg::FCP_Q_SIMPLE) : 2'(fcp_pkg::FCP_Q_ORDERED);
	assign O_TMF_VALID = r.tv;
	assign O_TMF_FLAGS = tmf;
	assign O_REJECT = r.rej;
	assign O_WDATA_VALID = r.dv;
	assign O_WDATA = r.dat;
	assign O_DONE = r.done;
	assign O_RSP_CODE = r.rc;
endmodule // fcp_target

// File: design/fcp_initiator.sv
`timescale 1ns/1ns
module fcp_initiator (
	input	wire logic			I_CLK,
	input	wire logic			I_RST,
	fcp_link_if.initiator			LINK,
	input	wire logic			I_START,
	input	wire logic [15:0]		I_XID,
	input	wire logic [255:0]		I_CMD,
	output	logic				O_BUSY,
	output	logic				O_XRDY_VALID,
	output	logic [31:0]			O_XRDY_OFFSET,
	output	logic [31:0]			O_XRDY_BURST
);
	typedef enum logic [1:0] {
		FCP_I_IDLE = 2'b00,
		FCP_I_CMD = 2'b01,
		FCP_I_WAIT = 2'b10,
		FCP_I_DATA = 2'b11
	} fcp_istate_t;
	typedef struct packed {
		fcp_istate_t	st;
		logic [255:0]	sh;
		logic [5:0]	cnt;
		logic [15:0]	xid;
		logic [95:0]	xr;
		logic [31:0]	left;
		logic [7:0]	pat;
		logic		xv;
		logic [31:0]	ro;
		logic [31:0]	bl;
	} fcp_ini_t;
	fcp_ini_t r;
	fcp_ini_t next_r;
	logic [31:0]	xr_ro;
	logic [31:0]	xr_bl;
	// RQ20 eleven bytes held, first on top
	assign xr_ro = r.xr[(fcp_pkg::XRDY_BYTES-1-fcp_pkg::RO_LO)*8-1 -: 32];
	assign xr_bl = r.xr[(fcp_pkg::XRDY_BYTES-1-fcp_pkg::BL_LO)*8-1 -: 32];
	always_comb begin
		next_r = r;
		next_r.xv = 1'b0;
		case (r.st)
			FCP_I_IDLE: begin
				if (I_START) begin
					// RQ3 32-byte command, first byte first
					next_r.sh = I_CMD;
					next_r.xid = I_XID;
					next_r.cnt = 6'd0;
					next_r.st = FCP_I_CMD;
				end
			end
			FCP_I_CMD: begin
				next_r.sh = {r.sh[247:0], 8'h00};
				next_r.cnt = r.cnt + 6'd1;
				if (r.cnt == 6'(fcp_pkg::CMD_BYTES - 1)) begin
					next_r.st = FCP_I_WAIT;
				end
			end
			FCP_I_WAIT: begin
				// RQ12 zero length ends with no data
				if (I_START) begin
					next_r.st = FCP_I_IDLE;
				end else if (LINK.t2i_valid && LINK.t2i_xid == r.xid &&
				    LINK.t2i_cat == fcp_pkg::CAT_XRDY) begin
					next_r.xr = {r.xr[87:0], LINK.t2i_data};
					if (LINK.t2i_eof) begin
						next_r.xv = 1'b1;
						// RQ15 offset then burst
						next_r.ro = xr_ro;
						next_r.bl = xr_bl;
						// RQ16 send exactly the burst
						next_r.left = xr_bl;
						if (xr_bl != 32'h0) begin
							next_r.st = FCP_I_DATA;
						end
					end
				end
			end
			FCP_I_DATA: begin
				// RQ14 exactly the requested bytes
				next_r.left = r.left - 32'h1;
				next_r.pat = r.pat + 8'h01;
				if (r.left == 32'h1) begin
					next_r.st = FCP_I_WAIT;
				end
			end
			default: begin
				next_r.st = FCP_I_IDLE;
			end
		endcase
	end
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end
	// RQ1 command category 6, data category 1
	assign LINK.i2t_valid = (r.st == FCP_I_CMD) || (r.st == FCP_I_DATA);
	assign LINK.i2t_cat = (r.st == FCP_I_DATA) ?
	    fcp_pkg::CAT_DATA : fcp_pkg::CAT_CMD;
	assign LINK.i2t_data = (r.st == FCP_I_DATA) ? r.pat : r.sh[255:248];
	assign LINK.i2t_sof = ((r.st == FCP_I_CMD) && r.cnt == 6'd0) ||
	    ((r.st == FCP_I_DATA) && r.left == r.bl);
	assign LINK.i2t_eof = ((r.st == FCP_I_CMD) &&
	    r.cnt == 6'(fcp_pkg::CMD_BYTES - 1)) ||
	    ((r.st == FCP_I_DATA) && r.left == 32'h1);
	assign LINK.i2t_xid = r.xid;
	assign O_BUSY = (r.st != FCP_I_IDLE);
	assign O_XRDY_VALID = r.xv;
	assign O_XRDY_OFFSET = r.ro;
	assign O_XRDY_BURST = r.bl;
endmodule // fcp_initiator

// File: tb/fcp_assertions.sv
`timescale 1ns/1ns
module fcp_assertions (
	input	wire logic		I_CLK,
	input	wire logic		I_RST,
	input	wire logic		i2t_valid,
	input	wire logic [7:0]	i2t_data,
	input	wire logic [3:0]	i2t_cat,
	input	wire logic		i2t_sof,
	input	wire logic		i2t_eof,
	input	wire logic [15:0]	i2t_xid,
	input	wire logic		t2i_valid,
	input	wire logic [7:0]	t2i_data,
	input	wire logic [3:0]	t2i_cat,
	input	wire logic		t2i_sof,
	input	wire logic		t2i_eof,
	input	wire logic [15:0]	t2i_xid
);
	logic [5:0]	ci;
	logic [3:0]	ti;
	logic [31:0]	dl, off, bl, tot, dc;
	logic [15:0]	xid;
	wire		cmd = i2t_valid && i2t_cat == fcp_pkg::CAT_CMD;
	wire		dat = i2t_valid && i2t_cat == fcp_pkg::CAT_DATA;
	default clocking @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// Byte indices assume frames start right after the previous eof
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			{ci, ti, dl, off, bl, tot, dc, xid} <= '0;
		end else begin
			if (i2t_valid) ci <= i2t_eof ? 6'h0 : ci + 6'h1;
			if (cmd && i2t_sof) xid <= i2t_xid;
			if (cmd && ci >= 6'h1C) dl <= {dl[23:0], i2t_data};
			if (cmd) tot <= 32'h0;
			if (dat) tot <= tot + 32'h1;
			if (dat) dc <= i2t_sof ? 32'h1 : dc + 32'h1;
			if (t2i_valid) ti <= t2i_eof ? 4'h0 : ti + 4'h1;
			if (t2i_valid && ti < 4'h4) off <= {off[23:0], t2i_data};
			if (t2i_valid && ti[3:2] == 2'b01) bl <= {bl[23:0], t2i_data};
		end
	end
	property p_rdy_cat;
		t2i_valid |-> t2i_cat == fcp_pkg::CAT_XRDY;
	endproperty
	a_rdy_cat: assert property (p_rdy_cat) else $error("ready category");
	property p_cmd_len;
		cmd && i2t_sof |-> ##31 (cmd && i2t_eof);
	endproperty
	a_cmd_len: assert property (p_cmd_len) else $error("command length");
	property p_rdy_len;
		t2i_valid && t2i_sof |-> ##11 (t2i_valid && t2i_eof);
	endproperty
	a_rdy_len: assert property (p_rdy_len) else $error("ready length");
	property p_rdy_rsvd;
		t2i_valid && t2i_sof |-> ##8 (t2i_valid && t2i_data == 8'h00)[*4];
	endproperty
	a_rdy_rsvd: assert property (p_rdy_rsvd) else $error("ready reserved");
	property p_tag;
		t2i_valid |-> t2i_xid == xid;
	endproperty
	a_tag: assert property (p_tag) else $error("ready exchange");
	property p_dat_tag;
		dat |-> i2t_xid == xid;
	endproperty
	a_dat_tag: assert property (p_dat_tag) else $error("data exchange");
	property p_rdy_off;
		t2i_valid && ti == 4'h4 |-> off == tot;
	endproperty
	a_rdy_off: assert property (p_rdy_off) else $error("ready offset");
	property p_bound;
		t2i_valid && t2i_eof |-> {1'b0, off} + {1'b0, bl} <= {1'b0, dl};
	endproperty
	a_bound: assert property (p_bound) else $error("burst past length");
	property p_zero_dl;
		t2i_valid && t2i_sof |-> dl != 32'h0;
	endproperty
	a_zero_dl: assert property (p_zero_dl) else $error("ready at zero");
	property p_burst;
		dat && i2t_eof |-> (i2t_sof ? 32'h1 : dc + 32'h1) == bl;
	endproperty
	a_burst: assert property (p_burst) else $error("data length");
	property p_dat_gap;
		t2i_valid && t2i_eof |-> ##[1:4] (dat && i2t_sof);
	endproperty
	a_dat_gap: assert property (p_dat_gap) else $error("no data");
endmodule // fcp_assertions

// File: tb/fcp_info_unit_handler_tb_top.sv
`timescale 1ns/1ns
module fcp_info_unit_handler_tb_top;
	logic		clk = 1'b0;
	logic		rst = 1'b1;
	logic		start = 1'b0;
	logic		buf_ready = 1'b0;
	logic [31:0]	max_burst = 32'h4;
	logic [15:0]	xid = 16'h0;
	logic [255:0]	cmd = '0;
	logic		cmd_v, rd, wr, tmf_v, rej, wd_v, done, busy, xr_v;
	logic [15:0]	tag;
	logic [127:0]	cdb;
	logic [31:0]	dl, xr_off, xr_bl;
	logic [1:0]	queue;
	logic [7:0]	tmf_f, wd, rsp;
	logic [31:0]	xr_q[$];
	logic [31:0]	xe[6] = '{0, 4, 4, 4, 8, 2};
	logic [7:0]	at_t[8] = '{0, 1, 2, 5, 8'hFA, 4, 3, 7};
	logic [1:0]	q_t[5] = '{0, 1, 2, 2, 2};
	logic [7:0]	tm_t[6] = '{8'h80, 8'h20, 8'h04, 8'h02, 8'h40, 8'h06};
	// Tail bytes of the descriptor deliberately junk
	localparam logic [127:0] CDB_V = 128'h2A000000100000000A00FFFFFFFFFFFF;
	int		n_fail = 0;
	int		check_count = 0;
	int		n_cmd, n_tmf, n_rej, n_done, n_wd, wd_seen, wd_bad, i;
	fcp_link_if link ();
	fcp_target fcp_target_i (.I_CLK(clk), .I_RST(rst), .LINK(link),
		.I_MAX_BURST(max_burst), .I_BUF_READY(buf_ready),
		.O_CMD_VALID(cmd_v), .O_CMD_TAG(tag), .O_CMD_CDB(cdb),
		.O_CMD_DL(dl), .O_CMD_READ(rd), .O_CMD_WRITE(wr),
		.O_CMD_QUEUE(queue), .O_TMF_VALID(tmf_v), .O_TMF_FLAGS(tmf_f),
		.O_REJECT(rej), .O_WDATA_VALID(wd_v), .O_WDATA(wd),
		.O_DONE(done), .O_RSP_CODE(rsp));
	fcp_initiator fcp_initiator_i (.I_CLK(clk), .I_RST(rst), .LINK(link),
		.I_START(start), .I_XID(xid), .I_CMD(cmd), .O_BUSY(busy),
		.O_XRDY_VALID(xr_v), .O_XRDY_OFFSET(xr_off),
		.O_XRDY_BURST(xr_bl));
	fcp_assertions fcp_assertions_i (.I_CLK(clk), .I_RST(rst),
		.i2t_valid(link.i2t_valid), .i2t_data(link.i2t_data),
		.i2t_cat(link.i2t_cat), .i2t_sof(link.i2t_sof),
		.i2t_eof(link.i2t_eof), .i2t_xid(link.i2t_xid),
		.t2i_valid(link.t2i_valid), .t2i_data(link.t2i_data),
		.t2i_cat(link.t2i_cat), .t2i_sof(link.t2i_sof),
		.t2i_eof(link.t2i_eof), .t2i_xid(link.t2i_xid));
	always #10 clk = ~clk;
	always @(posedge clk) begin
		n_cmd += int'(cmd_v);
		n_tmf += int'(tmf_v);
		n_rej += int'(rej);
		n_done += int'(done);
		// initiator pattern counts every data byte sent
		if (wd_v && wd !== 8'(wd_seen)) wd_bad++;
		wd_seen += int'(wd_v);
		n_wd += int'(wd_v);
		if (xr_v) xr_q.push_back(xr_off);
		if (xr_v) xr_q.push_back(xr_bl);
	end
	task chk(input logic [127:0] got, input logic [127:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task end_of_test;
		$display("checks=%0d fails=%0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	function automatic logic [255:0] mk(logic [63:0] lun, logic [7:0] at,
		logic [7:0] tm, logic [7:0] dr, logic [31:0] len);
		return {lun, 8'h00, at, tm, dr, CDB_V, len};
	endfunction
	task run(input logic [255:0] c, input logic [15:0] x);
		int k;
		{n_cmd, n_tmf, n_rej, n_done, n_wd} = '0;
		xr_q = {};
		cmd = c;
		xid = x;
		start = 1'b1;
		@(negedge clk);
		start = 1'b0;
		for (k = 0; k < 3000 && n_done + n_rej == 0; k++) @(negedge clk);
		if (k == 3000) begin
			n_fail++;
			end_of_test();
		end
		repeat (4) @(negedge clk);
		// Initiator parks waiting for a ready unit that never comes
		if (busy === 1'b1) begin
			start = 1'b1;
			@(negedge clk);
			start = 1'b0;
			// Let an edge pass before the next start
			@(negedge clk);
		end
	endtask
	initial begin
		repeat (12) @(negedge clk);
		rst = 1'b0;
		fork
			run(mk(64'h0, 8'hF9, 8'h00, 8'h01, 32'hA), 16'h1234);
			begin
				repeat (80) @(negedge clk);
				chk(xr_q.size(), 0);
				buf_ready = 1'b1;
			end
		join
		chk(n_cmd, 1);
		chk(tag, 16'h1234);
		chk(cdb, CDB_V);
		chk(dl, 32'hA);
		chk({rd, wr, queue}, 4'b0101);
		chk(xr_q.size(), 6);
		for (i = 0; i < 6; i++) chk(xr_q[i], xe[i]);
		chk(n_wd, 10);
		chk(rsp, fcp_pkg::RC_OK);
		chk({wd_bad, wd}, {32'd0, 8'h09});
		$display("test write done");
		max_burst = 32'h10;
		run(mk(64'h0, 8'h00, 8'h00, 8'h01, 32'hA), 16'h1235);
		chk({xr_q.size(), xr_q[0], xr_q[1]}, {32'd2, 32'h0, 32'hA});
		chk({n_wd, wd_bad, wd}, {32'd10, 32'd0, 8'h13});
		$display("test single burst done");
		for (i = 0; i < 8; i++) begin
			run(mk(64'h0, at_t[i], 8'h00, 8'h02, 32'h200),
				16'h20 + 16'(i));
			if (i < 5) begin
				chk(queue, q_t[i]);
				chk({n_cmd, rd, wr}, {32'd1, 2'b10});
			end else begin
				chk({n_rej, n_cmd}, {32'd1, 32'd0});
				chk(rsp, fcp_pkg::RC_REJECT);
			end
		end
		$display("test attributes done");
		for (i = 0; i < 6; i++) begin
			run(mk(64'h0, 8'h04, tm_t[i], 8'h01, 32'h40),
				16'h40 + 16'(i));
			chk({n_cmd, xr_q.size()}, 64'h0);
			if (i < 4) chk({n_tmf, tmf_f}, {32'd1, tm_t[i]});
			else chk(rsp, i == 4 ? 8'h04 : 8'h02);
		end
		$display("test management done");
		run(mk(64'h1, 8'h00, 8'h00, 8'h02, 32'h10), 16'h50);
		chk({n_rej, rsp}, {32'd1, fcp_pkg::RC_INVALID});
		run(mk(64'h0, 8'h00, 8'h00, 8'h01, 32'h0), 16'h51);
		chk({n_cmd, n_done, n_wd, xr_q.size()}, {32'd1, 32'd1, 64'h0});
		$display("test lun and zero length done");
		end_of_test();
	end
endmodule // fcp_info_unit_handler_tb_top
